// *** src/cmsrs_top.v ***
// codec mode strap capture, reset sequence and status output
`timescale 1ns/1ps
`default_nettype none
`include "cmsrs_defs.vh"

module cmsrs_top #(
   parameter NDOUT = 3,
   parameter RESET_SEQ_NS = `CMSRS_RESET_SEQ_NS
) (
   input  wire             CLK_SYS,
   input  wire             RSTN,
   input  wire             RESET_PIN_N,
   input  wire             STRAP_LEVEL,
   output reg              STRAP_PROBE_UP,
   output reg              STRAP_PROBE_DN,
   output reg  [1:0]       MODE_STATE,
   output reg              MODE_VALID,
   output reg              CORE_RESET_N,
   input  wire             ADC_OVERFLOW,
   output reg              OVERFLOW_READY_FLAG,
   input  wire             POWER_SAVE,
   input  wire             ADC_MASTER,
   input  wire             DAC_MASTER,
   input  wire [3:0]       CORE_CLK,
   input  wire [NDOUT-1:0] CORE_SDOUT,
   input  wire [3:0]       CLK_PIN_I,
   output reg  [3:0]       CLK_PIN_O,
   output reg  [3:0]       CLK_PIN_OE,
   output reg  [3:0]       CLK_SYNC,
   output reg  [NDOUT-1:0] ADC_SERIAL_OUTPUTS
);

   // ****************************************************************
   // timing counts
   // ****************************************************************
   localparam integer SETTLE_CYC = (`CMSRS_STRAP_SETTLE_NS + `CMSRS_CLK_NS - 1) / `CMSRS_CLK_NS;
   localparam integer SEQ_CYC    = (RESET_SEQ_NS + `CMSRS_CLK_NS - 1) / `CMSRS_CLK_NS;
   localparam integer READY_CYC  = (`CMSRS_READY_PULSE_NS + `CMSRS_CLK_NS - 1) / `CMSRS_CLK_NS;
   localparam integer SETTLE_END = SETTLE_CYC - 1;
   localparam integer SEQ_END    = SEQ_CYC - 1;
   localparam integer READY_END  = READY_CYC - 1;
   // counter compares are 16 bits wide, cut on purpose
   localparam [15:0]  SETTLE_LAST = SETTLE_END[15:0];
   localparam [15:0]  SEQ_LAST    = SEQ_END[15:0];
   localparam [15:0]  READY_LAST  = READY_END[15:0];

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [2:0] S_HOLD  = 3'h0;
   localparam [2:0] S_P_OFF = 3'h1;
   localparam [2:0] S_P_UP  = 3'h2;
   localparam [2:0] S_P_DN  = 3'h3;
   localparam [2:0] S_SEQ   = 3'h4;
   localparam [2:0] S_READY = 3'h5;
   localparam [2:0] S_RUN   = 3'h6;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [15:0] cnt_r;
   reg  [15:0] cnt_nxt;
   reg         lvl_off_r;
   reg         lvl_up_r;
   reg         pin_prev_r;
   reg  [1:0]  mode_nxt;
   wire        pin_sync;
   wire [3:0]  clk_sync_w;
   wire [3:0]  pin_oe_nxt;
   wire [3:0]  pin_o_nxt;
   wire        pin_rise;
   wire        cnt_done;

   // ****************************************************************
   // synchronisers for reset pin and slave clocks
   // ****************************************************************
   cmsrs_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
      .clk   (CLK_SYS),
      .rst_n (RSTN),
      .d     (RESET_PIN_N),
      .q     (pin_sync)
   );

   cmsrs_sync #(.WIDTH(4), .INIT(4'h0)) u_clk_sync (
      .clk   (CLK_SYS),
      .rst_n (RSTN),
      .d     (CLK_PIN_I),
      .q     (clk_sync_w)
   );

   // rising edge of the synchronised reset pin
   assign pin_rise = pin_sync & ~pin_prev_r;
   assign cnt_done = ((state_r == S_P_OFF || state_r == S_P_UP || state_r == S_P_DN) && cnt_r == SETTLE_LAST) ||
                     (state_r == S_SEQ && cnt_r == SEQ_LAST) ||
                     (state_r == S_READY && cnt_r == READY_LAST);

   // ****************************************************************
   // strap decode
   // ****************************************************************
   // probe off, up, down: a hard tie wins every probe, a resistor loses
   always @* begin
      if (lvl_up_r && STRAP_LEVEL)
         mode_nxt = `CMSRS_MODE_TIED_HI;
      else if (!lvl_up_r && !STRAP_LEVEL)
         mode_nxt = `CMSRS_MODE_TIED_LO;
      else if (lvl_off_r)
         mode_nxt = `CMSRS_MODE_PULL_UP;
      else
         mode_nxt = `CMSRS_MODE_PULL_DN;
   end

   // ****************************************************************
   // sequence control
   // ****************************************************************
   // next state: pin low always holds, a rise restarts capture
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r + 16'h0001;
      if (!pin_sync) begin
         state_nxt = S_HOLD;
         cnt_nxt   = 16'h0000;
      end else if (pin_rise) begin
         state_nxt = S_P_OFF;
         cnt_nxt   = 16'h0000;
      end else if (cnt_done) begin
         cnt_nxt = 16'h0000;
         case (state_r)
            S_P_OFF: state_nxt = S_P_UP;
            S_P_UP:  state_nxt = S_P_DN;
            S_P_DN:  state_nxt = S_SEQ;
            S_SEQ:   state_nxt = S_READY;
            S_READY: state_nxt = S_RUN;
            default: state_nxt = S_RUN;
         endcase
      end else if (state_r == S_HOLD || state_r == S_RUN) begin
         cnt_nxt = 16'h0000;
      end
   end

   // state, counter, probe samples and mode latch
   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         state_r    <= S_P_OFF; // power-on capture follows release
         cnt_r      <= 16'h0000;
         pin_prev_r <= 1'b1;
         lvl_off_r  <= 1'b0;
         lvl_up_r   <= 1'b0;
         MODE_STATE <= `CMSRS_MODE_RESET;
         MODE_VALID <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         pin_prev_r <= pin_sync;
         if (cnt_done && pin_sync && !pin_rise && state_r == S_P_OFF)
            lvl_off_r <= STRAP_LEVEL;
         if (cnt_done && pin_sync && !pin_rise && state_r == S_P_UP)
            lvl_up_r <= STRAP_LEVEL;
         // mode changes only here, held otherwise
         if (cnt_done && pin_sync && !pin_rise && state_r == S_P_DN) begin
            MODE_STATE <= mode_nxt;
            MODE_VALID <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // status and core reset outputs
   // ****************************************************************
   // flag pulses when ready, then follows adc overflow
   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         OVERFLOW_READY_FLAG <= 1'b0;
         CORE_RESET_N        <= 1'b0;
         STRAP_PROBE_UP      <= 1'b0;
         STRAP_PROBE_DN      <= 1'b0;
      end else begin
         CORE_RESET_N   <= (state_nxt == S_READY || state_nxt == S_RUN);
         STRAP_PROBE_UP <= (state_nxt == S_P_UP);
         STRAP_PROBE_DN <= (state_nxt == S_P_DN);
         if (state_nxt == S_READY)
            OVERFLOW_READY_FLAG <= 1'b1;
         else if (state_nxt == S_RUN)
            OVERFLOW_READY_FLAG <= ADC_OVERFLOW;
         else
            OVERFLOW_READY_FLAG <= 1'b0;
      end
   end

   // ****************************************************************
   // audio clock and data pins, all on the system clock
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_clk
         wire master_w = (gi < 2) ? ADC_MASTER : DAC_MASTER;
         // driven low in power-save, inputs in slave mode
         assign pin_oe_nxt[gi] = POWER_SAVE | master_w;
         assign pin_o_nxt[gi]  = ~POWER_SAVE & master_w & CORE_CLK[gi];
      end
   endgenerate

   // pin drive and slave clock registers, one process for all pins
   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         CLK_PIN_O  <= 4'h0;
         CLK_PIN_OE <= 4'h0;
         CLK_SYNC   <= 4'h0;
      end else begin
         CLK_PIN_O  <= pin_o_nxt;
         CLK_PIN_OE <= pin_oe_nxt;
         CLK_SYNC   <= clk_sync_w;
      end
   end

   // serial data outputs, static low in power-save or reset
   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN)
         ADC_SERIAL_OUTPUTS <= {NDOUT{1'b0}};
      else if (POWER_SAVE || !CORE_RESET_N)
         ADC_SERIAL_OUTPUTS <= {NDOUT{1'b0}};
      else
         ADC_SERIAL_OUTPUTS <= CORE_SDOUT;
   end

endmodule // cmsrs_top

`default_nettype wire

// *** inc/cmsrs_defs.vh ***
// constants of the codec mode strap and reset status block
`ifndef CMSRS_DEFS_VH
`define CMSRS_DEFS_VH

// ****************************************************************
// strap states
// ****************************************************************
`define CMSRS_MODE_TIED_LO   2'h0
`define CMSRS_MODE_PULL_DN   2'h1
`define CMSRS_MODE_PULL_UP   2'h2
`define CMSRS_MODE_TIED_HI   2'h3
`define CMSRS_MODE_RESET     2'h0

// ****************************************************************
// timing, in ns, clock at 200 MHz
// ****************************************************************
`define CMSRS_CLK_NS         5
`define CMSRS_STRAP_SETTLE_NS 1000
`define CMSRS_RESET_SEQ_NS   4000
`define CMSRS_READY_PULSE_NS 100

// ****************************************************************
// clock pin indices
// ****************************************************************
`define CMSRS_PIN_ADC_BIT    0
`define CMSRS_PIN_ADC_FRAME  1
`define CMSRS_PIN_DAC_BIT    2
`define CMSRS_PIN_DAC_FRAME  3

`endif

// *** src/cmsrs_sync.v ***
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none

module cmsrs_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // first stage feeds the second only
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         sync_r <= INIT;
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;

endmodule // cmsrs_sync

`default_nettype wire

// *** tb/cmsrs_strap_model.sv ***
// board strap pad model: strap kind seen through the internal probes
`timescale 1ns/1ps
`default_nettype none
`include "cmsrs_defs.vh"
module cmsrs_strap_model (
   input  wire logic [1:0] kind,
   input  wire logic       probe_up,
   input  wire logic       probe_dn,
   output var  logic       level
);
   // a tie beats both probes, a 220k resistor yields to a probe
   always_comb begin
      case (kind)
         `CMSRS_MODE_TIED_HI: level = 1'b1;
         `CMSRS_MODE_TIED_LO: level = 1'b0;
         `CMSRS_MODE_PULL_UP: level = !probe_dn;
         default:             level = probe_up;
      endcase
   end
endmodule // cmsrs_strap_model
`default_nettype wire

// *** tb/cmsrs_assertions.sv ***
// port checker of the mode strap and reset status block
`timescale 1ns/1ps
`default_nettype none
module cmsrs_assertions #(parameter NDOUT = 3) (
   input wire logic             CLK_SYS,
   input wire logic             RSTN,
   input wire logic             RESET_PIN_N,
   input wire logic             STRAP_PROBE_UP,
   input wire logic             STRAP_PROBE_DN,
   input wire logic [1:0]       MODE_STATE,
   input wire logic             MODE_VALID,
   input wire logic             CORE_RESET_N,
   input wire logic             ADC_OVERFLOW,
   input wire logic             OVERFLOW_READY_FLAG,
   input wire logic             POWER_SAVE,
   input wire logic             ADC_MASTER,
   input wire logic             DAC_MASTER,
   input wire logic [3:0]       CORE_CLK,
   input wire logic [3:0]       CLK_PIN_I,
   input wire logic [3:0]       CLK_PIN_O,
   input wire logic [3:0]       CLK_PIN_OE,
   input wire logic [3:0]       CLK_SYNC,
   input wire logic [NDOUT-1:0] ADC_SERIAL_OUTPUTS
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   // per-pin master enables
   wire logic [3:0] mst = {DAC_MASTER, DAC_MASTER, ADC_MASTER, ADC_MASTER};
   mode_hold_a: assert property ((!$stable(MODE_STATE) || $rose(MODE_VALID)) |-> $past(STRAP_PROBE_DN))
      else $error("mode changed outside a capture");
   probe_excl_a: assert property (!(STRAP_PROBE_UP && STRAP_PROBE_DN))
      else $error("both probes on");
   probe_order_a: assert property ($rose(STRAP_PROBE_DN) |-> $past(STRAP_PROBE_UP))
      else $error("down probe not after up probe");
   probe_hold_a: assert property ($rose(STRAP_PROBE_UP) |-> STRAP_PROBE_UP[*8])
      else $error("up probe too short");
   pin_hold_a: assert property ((!RESET_PIN_N)[*4] |-> !CORE_RESET_N && !OVERFLOW_READY_FLAG)
      else $error("reset pin low without hold");
   ready_pulse_a: assert property ($rose(CORE_RESET_N) |-> OVERFLOW_READY_FLAG[*8])
      else $error("no ready pulse");
   flag_seq_a: assert property (!CORE_RESET_N |-> !OVERFLOW_READY_FLAG)
      else $error("flag high during sequence");
   flag_follow_a: assert property (CORE_RESET_N && $past(CORE_RESET_N, 22) |->
      OVERFLOW_READY_FLAG == $past(ADC_OVERFLOW))
      else $error("flag not following overflow");
   save_low_a: assert property ($past(RSTN) && $past(POWER_SAVE) |->
      ADC_SERIAL_OUTPUTS == '0 && CLK_PIN_O == 4'h0 && CLK_PIN_OE == 4'hF)
      else $error("outputs not low in power-save");
   pin_drive_a: assert property ($past(RSTN) && !$past(POWER_SAVE) |->
      CLK_PIN_OE == $past(mst) && CLK_PIN_O == ($past(mst) & $past(CORE_CLK)))
      else $error("clock pin drive wrong");
   slave_sync_a: assert property ($past(RSTN, 3) && $past(RSTN, 2) && $past(RSTN) |->
      CLK_SYNC == $past(CLK_PIN_I, 3))
      else $error("slave clock sync wrong");
endmodule // cmsrs_assertions
bind cmsrs_top cmsrs_assertions #(.NDOUT(NDOUT)) u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
   .RESET_PIN_N(RESET_PIN_N), .STRAP_PROBE_UP(STRAP_PROBE_UP), .STRAP_PROBE_DN(STRAP_PROBE_DN),
   .MODE_STATE(MODE_STATE), .MODE_VALID(MODE_VALID), .CORE_RESET_N(CORE_RESET_N),
   .ADC_OVERFLOW(ADC_OVERFLOW), .OVERFLOW_READY_FLAG(OVERFLOW_READY_FLAG), .POWER_SAVE(POWER_SAVE),
   .ADC_MASTER(ADC_MASTER), .DAC_MASTER(DAC_MASTER), .CORE_CLK(CORE_CLK), .CLK_PIN_I(CLK_PIN_I),
   .CLK_PIN_O(CLK_PIN_O), .CLK_PIN_OE(CLK_PIN_OE), .CLK_SYNC(CLK_SYNC),
   .ADC_SERIAL_OUTPUTS(ADC_SERIAL_OUTPUTS));
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the mode strap and reset status block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rstn, pin_n, ovf, ps, am, dm, pu, pd, lvl, mv, crn, flag;
   logic [3:0]  cclk, pi, po, poe, psync, mst;
   logic [2:0]  sdi, sdo;
   logic [1:0]  ms, kind, prev;
   logic [11:0] hist;
   logic [31:0] lfsr_r;
   int          failures, n_tests, n, j;
   cmsrs_top #(.NDOUT(3), .RESET_SEQ_NS(200)) dut (.CLK_SYS(clk), .RSTN(rstn), .RESET_PIN_N(pin_n),
      .STRAP_LEVEL(lvl), .STRAP_PROBE_UP(pu), .STRAP_PROBE_DN(pd), .MODE_STATE(ms), .MODE_VALID(mv),
      .CORE_RESET_N(crn), .ADC_OVERFLOW(ovf), .OVERFLOW_READY_FLAG(flag), .POWER_SAVE(ps),
      .ADC_MASTER(am), .DAC_MASTER(dm), .CORE_CLK(cclk), .CORE_SDOUT(sdi), .CLK_PIN_I(pi),
      .CLK_PIN_O(po), .CLK_PIN_OE(poe), .CLK_SYNC(psync), .ADC_SERIAL_OUTPUTS(sdo));
   cmsrs_strap_model u_strap (.kind(kind), .probe_up(pu), .probe_dn(pd), .level(lvl));
   // one system clock for everything
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   // wait for the sequence end and check its length, mode and ready flag
   task automatic ready_check(input logic [1:0] exp);
      n = 0;
      while (crn !== 1'b1 && n < 2000) begin
         cyc(1);
         n++;
      end
      check(8'(n >= 638 && n <= 650), 8'h01);
      check(8'(ms), 8'(exp));
      check(8'({mv, flag}), 8'h03);
   endtask
   initial begin
      {failures, n_tests, ovf, ps, am, dm, cclk, sdi, pi, hist} = '0;
      lfsr_r = 32'h00010C69;
      rstn = 1'b0;
      pin_n = 1'b1;
      kind = 2'h2;
      cyc(4);
      rstn = 1'b1;
      ready_check(2'h2);
      // every strap kind, then the abort case with a strap change while held
      for (j = 0; j < 5; j++) begin
         prev = ms;
         kind = (j == 4) ? 2'h0 : 2'(j) ^ 2'h1;
         cyc(50);
         check(8'(ms), 8'(prev));
         pin_n = 1'b0;
         cyc(4);
         check(8'({crn, flag}), 8'h00);
         pin_n = 1'b1;
         if (j == 4) begin
            cyc(300);
            pin_n = 1'b0;
            kind = 2'h3;
            cyc(4);
            check(8'(ms), 8'(prev));
            pin_n = 1'b1;
         end
         ready_check(kind);
         cyc(21);
         repeat (8) begin
            lfsr_r = lfsr_next(lfsr_r);
            ovf = lfsr_r[0];
            cyc(1);
            check(8'(flag), 8'(ovf));
         end
      end
      // ordered power-down: save on with core clocks frozen, then save off
      {am, dm, cclk, sdi} = {2'h3, 4'hA, 3'h5};
      ps = 1'b1;
      cyc(6);
      check({poe, po}, 8'hF0);
      check(8'(sdo), 8'h00);
      ps = 1'b0;
      cyc(1);
      check({poe, po}, 8'hFA);
      check(8'(sdo), 8'h05);
      // random pin traffic; power-save enter and leave
      repeat (60) begin
         lfsr_r = lfsr_next(lfsr_r);
         {ps, am, dm, cclk, sdi, pi} = lfsr_r[13:0];
         mst = {dm, dm, am, am};
         hist = {hist[7:0], pi};
         cyc(1);
         check({poe, po}, ps ? 8'hF0 : {mst, mst & cclk});
         check(8'(sdo), ps ? 8'h00 : 8'(sdi));
         check(8'(psync), 8'(hist[11:8]));
      end
      ps = 1'b0;
      rstn = 1'b0;
      kind = 2'h1;
      cyc(2);
      check(8'({ms, mv, crn}), 8'h00);
      rstn = 1'b1;
      ready_check(2'h1);
      test_done;
   end
   // hang guard
   initial begin
      #75000;
      failures++;
      test_done;
   end
endmodule // tb
`default_nettype wire
